// >>> hdl/ccfi_params.svh
// Register map, field positions and reset values of the side channel fault block.
`ifndef CCFI_PARAMS_SVH
`define CCFI_PARAMS_SVH
`define CCFI_ADDR_W        12
`define CCFI_IDX_STATUS    8'h6C
`define CCFI_IDX_CONFIG    8'h6E
`define CCFI_IDX_TEST      8'h6F
`define CCFI_IDX_TGT1      8'h70
`define CCFI_IDX_TGT2      8'h71
`define CCFI_IDX_TGT3      8'h72
`define CCFI_CFG_RESET     8'h20
`define CCFI_CFG_WMASK     8'h3F
`define CCFI_CFG_ENH_BIT   0
`define CCFI_CFG_TERM_BIT  4
`define CCFI_TEST_WMASK    8'h3F
`define CCFI_TEST_TRIG_BIT 6
`define CCFI_TYPE_MSB      5
`define CCFI_TYPE_LSB      3
`define CCFI_SEL_MSB       2
`define CCFI_SEL_LSB       0
`define CCFI_TGT_WMASK     8'hFE
`define CCFI_ZERO_BYTE     8'h00
`define CCFI_ZERO_WORD     32'h0000_0000
`define CCFI_RW_BIT        0
`define CCFI_STAT_ARMED    0
`define CCFI_LFSR_SEED     3'h1
`define CCFI_SEQ_STEP      4'h1
`define CCFI_SEQ_SKIP      4'h2
`define CCFI_POS_STEP      3'h1
`endif

// >>> hdl/ccfi_pkg.sv
// Types shared by the side channel fault block and its helpers.
`default_nettype none
package ccfi_pkg;
   // Fault kinds selected by the type field.
   typedef enum logic [2:0] {
      CCFI_FT_NONE = 3'b000,
      CCFI_FT_CRC  = 3'b001,
      CCFI_FT_SKIP = 3'b010,
      CCFI_FT_DROP = 3'b011,
      CCFI_FT_RAND = 3'b100,
      CCFI_FT_BIT0 = 3'b101,
      CCFI_FT_RSV6 = 3'b110,
      CCFI_FT_RSV7 = 3'b111
   } ccfi_fault_t;
   // Injection sequencer states.
   typedef enum logic [1:0] {
      CCFI_ST_IDLE   = 2'b00,
      CCFI_ST_ARMED  = 2'b01,
      CCFI_ST_ACTIVE = 2'b10
   } ccfi_state_t;
   // Decoded register selection.
   typedef enum logic [2:0] {
      CCFI_R_NONE   = 3'b000,
      CCFI_R_STATUS = 3'b001,
      CCFI_R_CONFIG = 3'b010,
      CCFI_R_TEST   = 3'b011,
      CCFI_R_TGT1   = 3'b100,
      CCFI_R_TGT2   = 3'b101,
      CCFI_R_TGT3   = 3'b110
   } ccfi_reg_t;
   // Control byte as handed over by the channel framer.
   typedef struct packed {
      logic       sof;
      logic       start_cmd;
      logic [7:0] data;
      logic [7:0] crc;
   } ccfi_payload_t;
   // Control frame as sent on the forward channel.
   typedef struct packed {
      logic [3:0]    seq;
      ccfi_payload_t pay;
   } ccfi_frame_t;
endpackage
`default_nettype wire

// >>> hdl/ccfi_lfsr.sv
// Three bit pseudo random source, advanced only while step_i is high, giving a data bit index 1 to 7.
`default_nettype none
`include "ccfi_params.svh"
module ccfi_lfsr (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       step_i,
   output logic [2:0]      idx_o
);
   logic [2:0] state;       // Shift register, never zero.
   logic [2:0] next_state;  // Value after the next step.

   // A maximal length polynomial never reaches zero, so bit 0 is never picked.
   always_comb begin
      next_state = state;
      if (step_i) begin
         // Taps on bits 2 and 0 run through all seven nonzero states.
         next_state = {state[1:0], state[2] ^ state[0]};
      end
   end

   // Register the sequence.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= `CCFI_LFSR_SEED;
      end else begin
         state <= next_state;
      end
   end

   assign idx_o = state;
endmodule
`default_nettype wire

// >>> hdl/ccfi_frame_fault.sv
// Combinational corruption of one control frame according to a fault kind.
`default_nettype none
`include "ccfi_params.svh"
module ccfi_frame_fault (
   input  wire ccfi_pkg::ccfi_payload_t pay_i,
   input  wire logic                    apply_i,
   input  wire ccfi_pkg::ccfi_fault_t   kind_i,
   input  wire logic [2:0]              rand_idx_i,
   output ccfi_pkg::ccfi_payload_t      pay_o,
   output logic                         drop_o,
   output logic                         skip_o
);
   import ccfi_pkg::*;

   // Only the selected frame is touched; all others pass unchanged.
   always_comb begin
      pay_o  = pay_i;
      drop_o = 1'b0;
      skip_o = 1'b0;
      if (apply_i) begin
         case (kind_i)
            CCFI_FT_CRC:  pay_o.crc = ~pay_i.crc;
            CCFI_FT_SKIP: skip_o = 1'b1;
            CCFI_FT_DROP: drop_o = 1'b1;
            CCFI_FT_RAND: pay_o.data[rand_idx_i] = ~pay_i.data[rand_idx_i];
            CCFI_FT_BIT0: pay_o.data[`CCFI_RW_BIT] = ~pay_i.data[`CCFI_RW_BIT];
            default: begin
               // No fault, and reserved codes behave as no fault.
               pay_o = pay_i;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> hdl/ccfi_top.sv
// Side channel control: error check enable, fault injection and remote target remap.
// How it works
// - Enhanced check enable gates error termination.
// - Trigger write corrupts one forward frame.
// - Trigger self clears and always reads zero.
// - Type 000 none, 001 CRC, 010 skip.
// - Type 011 drops the selected frame.
// - 100 flips random bit 1-7, 101 bit 0.
// - Byte select picks byte 0-7 of transfer.
// - Target entries hold 7-bit address, bit 0 zero.
// - Alias match n substitutes target entry n.
// - Three targets at 0x70-0x72, reset zero.
// - Abort on CRC ignored without enhanced check.
//
// Our own choice: the APB register port.
`default_nettype none
`include "ccfi_params.svh"
module ccfi_top (
   input  wire logic                    SYS_CLK_I,
   input  wire logic                    RESET_I,
   // APB slave.
   input  wire logic                    PSEL_I,
   input  wire logic                    PENABLE_I,
   input  wire logic                    PWRITE_I,
   input  wire logic [`CCFI_ADDR_W-1:0] PADDR_I,
   input  wire logic [31:0]             PWDATA_I,
   input  wire logic [3:0]              PSTRB_I,
   output logic                         PREADY_O,
   output logic [31:0]                  PRDATA_O,
   output logic                         PSLVERR_O,
   // Forward control bytes from the framer and frames to the link.
   input  wire logic                    FRAME_VALID_I,
   input  wire ccfi_pkg::ccfi_payload_t FRAME_I,
   output logic                         FRAME_VALID_O,
   output ccfi_pkg::ccfi_frame_t        FRAME_O,
   // Address phase of a local I2C transaction.
   input  wire logic                    ADDR_VALID_I,
   input  wire logic [1:0]              ALIAS_IDX_I,
   input  wire logic                    ADDR_RW_I,
   output logic                         REMAP_VALID_O,
   output logic [7:0]                   REMAP_ADDR_O,
   // Error conditions seen by the channel checker.
   input  wire logic                    CHK_ERROR_I,
   input  wire logic                    CRC_ERROR_I,
   output logic                         ABORT_O
);
   import ccfi_pkg::*;

   localparam int NUM_TGT = 3;  // Number of remote target entries.

   // Maps a byte address to a register; misaligned or unknown gives none.
   function automatic ccfi_reg_t decode(input logic [`CCFI_ADDR_W-1:0] a);
      ccfi_reg_t r;
      r = CCFI_R_NONE;
      if (a[1:0] == 2'b00) begin
         case (a[`CCFI_ADDR_W-1:2])
            10'(`CCFI_IDX_STATUS): r = CCFI_R_STATUS;
            10'(`CCFI_IDX_CONFIG): r = CCFI_R_CONFIG;
            10'(`CCFI_IDX_TEST):   r = CCFI_R_TEST;
            10'(`CCFI_IDX_TGT1):   r = CCFI_R_TGT1;
            10'(`CCFI_IDX_TGT2):   r = CCFI_R_TGT2;
            10'(`CCFI_IDX_TGT3):   r = CCFI_R_TGT3;
            default:               r = CCFI_R_NONE;
         endcase
      end
      return r;
   endfunction

   // ---------------- Register file and APB slave ----------------
   logic [7:0]  cfg;                // Configuration byte.
   logic [7:0]  test;               // Fault type and byte select.
   logic [7:0]  tgt [NUM_TGT];      // Remote target entries.
   logic [7:0]  next_cfg;           // Next configuration.
   logic [7:0]  next_test;          // Next test fields.
   logic [7:0]  next_tgt [NUM_TGT]; // Next target entries.
   logic        next_pready;        // Next ready.
   logic [31:0] next_prdata;        // Next read data.
   logic        next_pslverr;       // Next error answer.
   logic        trig;               // One-cycle trigger pulse.
   logic        access;             // Completing access phase.
   logic        wr_lane0;           // Write touches the low byte.
   ccfi_reg_t   sel;                // Decoded target register.
   ccfi_state_t state;              // Injection sequencer state.
   logic [3:0]  seq;                // Forward sequence counter.
   logic [7:0]  rd_byte;            // Byte chosen for a read.

   // Ready follows one wait cycle so read data comes from a flip-flop.
   always_comb begin
      sel          = decode(PADDR_I);
      access       = PSEL_I & PENABLE_I & PREADY_O;
      wr_lane0     = access & PWRITE_I & PSTRB_I[0];
      next_pready  = PSEL_I & PENABLE_I & ~PREADY_O;
      next_pslverr = next_pready & (sel == CCFI_R_NONE);
      next_cfg     = cfg;
      next_test    = test;
      trig         = 1'b0;
      rd_byte      = `CCFI_ZERO_BYTE;
      for (int i = 0; i < NUM_TGT; i++) begin
         next_tgt[i] = tgt[i];
      end
      case (sel)
         CCFI_R_STATUS: begin
            // Sequence counter and the armed flag show the block's state.
            rd_byte = {seq, 3'b000, state != CCFI_ST_IDLE};
         end
         CCFI_R_CONFIG: begin
            rd_byte = cfg;
            if (wr_lane0) begin
               next_cfg = PWDATA_I[7:0] & `CCFI_CFG_WMASK;
            end
         end
         CCFI_R_TEST: begin
            rd_byte = test;
            if (wr_lane0) begin
               next_test = PWDATA_I[7:0] & `CCFI_TEST_WMASK;
               trig      = PWDATA_I[`CCFI_TEST_TRIG_BIT];
            end
         end
         CCFI_R_TGT1, CCFI_R_TGT2, CCFI_R_TGT3: begin
            rd_byte = tgt[int'(sel) - int'(CCFI_R_TGT1)];
            if (wr_lane0) begin
               // Bit 0 is not stored, so it always reads zero.
               next_tgt[int'(sel) - int'(CCFI_R_TGT1)] = PWDATA_I[7:0] & `CCFI_TGT_WMASK;
            end
         end
         default: begin
            rd_byte = `CCFI_ZERO_BYTE;
         end
      endcase
      next_prdata = next_pready ? {24'h00_0000, rd_byte} : `CCFI_ZERO_WORD;
   end

   // Registers of the bus slave and the software visible state.
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         PREADY_O  <= 1'b0;
         PRDATA_O  <= `CCFI_ZERO_WORD;
         PSLVERR_O <= 1'b0;
         cfg       <= `CCFI_CFG_RESET;
         test      <= `CCFI_ZERO_BYTE;
         for (int i = 0; i < NUM_TGT; i++) begin
            tgt[i] <= `CCFI_ZERO_BYTE;
         end
      end else begin
         PREADY_O  <= next_pready;
         PRDATA_O  <= next_prdata;
         PSLVERR_O <= next_pslverr;
         cfg       <= next_cfg;
         test      <= next_test;
         for (int i = 0; i < NUM_TGT; i++) begin
            tgt[i] <= next_tgt[i];
         end
      end
   end

   // ---------------- Fault injection sequencer ----------------
   ccfi_state_t   next_state;   // Next sequencer state.
   ccfi_fault_t   kind;         // Kind captured at the trigger.
   ccfi_fault_t   next_kind;    // Next captured kind.
   logic [2:0]    tsel;         // Byte position captured at the trigger.
   logic [2:0]    next_tsel;    // Next captured position.
   logic [2:0]    pos;          // Position of the next byte in the transfer.
   logic [2:0]    next_pos;     // Next position.
   logic [2:0]    here;         // Position of the byte now offered.
   logic          apply;        // Corrupt the byte now offered.
   logic [2:0]    rand_idx;     // Random data bit index.
   ccfi_payload_t pay_f;        // Byte after corruption.
   logic          drop;         // Frame is suppressed.
   logic          skip;         // Sequence number is skipped.

   // Capturing the fields at the trigger keeps a later rewrite from moving
   // an injection that is already pending.
   always_comb begin
      next_state = state;
      next_kind  = kind;
      next_tsel  = tsel;
      next_pos   = pos;
      apply      = 1'b0;
      here       = FRAME_I.sof ? 3'b000 : pos;
      if (FRAME_VALID_I) begin
         next_pos = here + `CCFI_POS_STEP;
      end
      case (state)
         CCFI_ST_ARMED: begin
            // Wait for the first byte of the next transfer.
            if (FRAME_VALID_I & FRAME_I.sof) begin
               apply      = (tsel == 3'b000);
               next_state = apply ? CCFI_ST_IDLE : CCFI_ST_ACTIVE;
            end
         end
         CCFI_ST_ACTIVE: begin
            // A short transfer keeps the injection pending for the next one.
            if (FRAME_VALID_I & (here == tsel)) begin
               apply      = 1'b1;
               next_state = CCFI_ST_IDLE;
            end
         end
         CCFI_ST_IDLE: begin
            next_state = CCFI_ST_IDLE;
         end
         default: begin
            next_state = CCFI_ST_IDLE;
         end
      endcase
      // A trigger written at any time re-arms with the newly written fields.
      if (trig) begin
         next_state = CCFI_ST_ARMED;
         next_kind  = ccfi_fault_t'(PWDATA_I[`CCFI_TYPE_MSB:`CCFI_TYPE_LSB]);
         next_tsel  = PWDATA_I[`CCFI_SEL_MSB:`CCFI_SEL_LSB];
      end
   end

   // Sequencer registers.
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         state <= CCFI_ST_IDLE;
         kind  <= CCFI_FT_NONE;
         tsel  <= 3'b000;
         pos   <= 3'b000;
      end else begin
         state <= next_state;
         kind  <= next_kind;
         tsel  <= next_tsel;
         pos   <= next_pos;
      end
   end

   // Random index advances on every byte so repeated faults hit varied bits.
   ccfi_lfsr u_lfsr (
      .clk_i  (SYS_CLK_I),
      .rst_i  (RESET_I),
      .step_i (FRAME_VALID_I),
      .idx_o  (rand_idx)
   );

   // Corruption of the selected byte.
   ccfi_frame_fault u_fault (
      .pay_i      (FRAME_I),
      .apply_i    (apply),
      .kind_i     (kind),
      .rand_idx_i (rand_idx),
      .pay_o      (pay_f),
      .drop_o     (drop),
      .skip_o     (skip)
   );

   // ---------------- Forward frame output ----------------
   logic        next_fvalid;  // Next output valid.
   ccfi_frame_t next_frame;   // Next output frame.
   logic [3:0]  next_seq;     // Next sequence counter.

   // A dropped frame still uses its sequence number, so the far end sees a gap.
   always_comb begin
      next_fvalid    = FRAME_VALID_I & ~drop;
      next_frame     = FRAME_O;
      next_seq       = seq;
      if (FRAME_VALID_I) begin
         next_frame.pay = pay_f;
         next_frame.seq = skip ? seq + `CCFI_SEQ_STEP : seq;
         next_seq       = seq + (skip ? `CCFI_SEQ_SKIP : `CCFI_SEQ_STEP);
      end
   end

   // Output frame registers.
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         FRAME_VALID_O <= 1'b0;
         FRAME_O       <= '0;
         seq           <= 4'h0;
      end else begin
         FRAME_VALID_O <= next_fvalid;
         FRAME_O       <= next_frame;
         seq           <= next_seq;
      end
   end

   // ---------------- Address remap and error termination ----------------
   logic       next_rvalid;  // Next remap strobe.
   logic [7:0] next_raddr;   // Next remapped address byte.
   logic       next_abort;   // Next abort strobe.

   // Alias zero means no match; the address is then left to other logic.
   always_comb begin
      next_rvalid = ADDR_VALID_I & (ALIAS_IDX_I != 2'b00);
      next_raddr  = REMAP_ADDR_O;
      if (next_rvalid) begin
         next_raddr = {tgt[ALIAS_IDX_I - 2'b01][7:1], ADDR_RW_I};
      end
      // CRC termination only counts while enhanced checking is on.
      next_abort = cfg[`CCFI_CFG_ENH_BIT] &
                   (CHK_ERROR_I | (cfg[`CCFI_CFG_TERM_BIT] & CRC_ERROR_I));
   end

   // Remap and abort registers.
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         REMAP_VALID_O <= 1'b0;
         REMAP_ADDR_O  <= `CCFI_ZERO_BYTE;
         ABORT_O       <= 1'b0;
      end else begin
         REMAP_VALID_O <= next_rvalid;
         REMAP_ADDR_O  <= next_raddr;
         ABORT_O       <= next_abort;
      end
   end
endmodule
`default_nettype wire

// >>> verification/ccfi_deser_model.sv
// Behavioural remote deserializer that follows forward frame numbering and check bytes.
`default_nettype none
module ccfi_deser_model (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  frame_valid_i,
   input  wire ccfi_pkg::ccfi_frame_t frame_i,
   output logic [7:0]                 seq_gaps_o,
   output logic [7:0]                 crc_bad_o
);
   import ccfi_pkg::*;
   logic [3:0] exp_seq;      // Sequence number expected on the next frame.
   logic [3:0] next_exp_seq; // Next value of the expected number.
   logic [7:0] next_gaps;    // Next count of sequence gaps.
   logic [7:0] next_bad;     // Next count of frames with a wrong check byte.
   // The bench seals every byte with data xor 5A, so any corruption of data or check shows here.
   always_comb begin
      next_exp_seq = exp_seq;
      next_gaps = seq_gaps_o;
      next_bad = crc_bad_o;
      if (frame_valid_i) begin
         next_exp_seq = frame_i.seq + 4'h1;
         if (frame_i.seq != exp_seq) begin
            next_gaps = seq_gaps_o + 8'h01;
         end
         if (frame_i.pay.crc != (frame_i.pay.data ^ 8'h5A)) begin
            next_bad = crc_bad_o + 8'h01;
         end
      end
   end
   // Register the receiver state; numbering restarts at zero with the link.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         exp_seq <= 4'h0;
         seq_gaps_o <= 8'h00;
         crc_bad_o <= 8'h00;
      end else begin
         exp_seq <= next_exp_seq;
         seq_gaps_o <= next_gaps;
         crc_bad_o <= next_bad;
      end
   end
endmodule
`default_nettype wire

// >>> verification/ccfi_top_properties.sv
// Concurrent checks on the ports of the side channel fault block.
`default_nettype none
`include "ccfi_params.svh"
module ccfi_top_checker (
   input wire logic                    SYS_CLK_I,
   input wire logic                    RESET_I,
   input wire logic                    PSEL_I,
   input wire logic                    PENABLE_I,
   input wire logic                    PWRITE_I,
   input wire logic [`CCFI_ADDR_W-1:0] PADDR_I,
   input wire logic                    PREADY_O,
   input wire logic [31:0]             PRDATA_O,
   input wire logic                    FRAME_VALID_I,
   input wire logic                    FRAME_VALID_O,
   input wire logic                    ADDR_VALID_I,
   input wire logic [1:0]              ALIAS_IDX_I,
   input wire logic                    ADDR_RW_I,
   input wire logic                    REMAP_VALID_O,
   input wire logic [7:0]              REMAP_ADDR_O,
   input wire logic                    CHK_ERROR_I,
   input wire logic                    CRC_ERROR_I,
   input wire logic                    ABORT_O
);
   localparam logic [`CCFI_ADDR_W-1:0] TEST_A = {2'b00, `CCFI_IDX_TEST, 2'b00};
   localparam logic [`CCFI_ADDR_W-1:0] TGT1_A = {2'b00, `CCFI_IDX_TGT1, 2'b00};
   localparam logic [`CCFI_ADDR_W-1:0] TGT3_A = {2'b00, `CCFI_IDX_TGT3, 2'b00};
   logic rd_test;   // Answer to a read of the fault test register.
   logic rd_tgt;    // Answer to a read of a remote target entry.
   logic remap_req; // Address phase that matched an alias.
   assign rd_test = PREADY_O && !PWRITE_I && PADDR_I == TEST_A;
   assign rd_tgt = PREADY_O && !PWRITE_I && PADDR_I >= TGT1_A && PADDR_I <= TGT3_A && PADDR_I[1:0] == 2'b00;
   assign remap_req = ADDR_VALID_I && ALIAS_IDX_I != 2'b00;
   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (RESET_I);
   // The two phases of a bus transfer.
   sequence apb_setup;
      PSEL_I && !PENABLE_I;
   endsequence
   sequence apb_access;
      PSEL_I && PENABLE_I;
   endsequence
   apb_answer_a: assert property (apb_setup ##1 apb_access |=> PREADY_O ##1 !PREADY_O)
      else $error("bus answer missing or not one cycle long");
   rdata_idle_a: assert property (!PREADY_O |-> PRDATA_O == 32'h0000_0000)
      else $error("read data not zero outside an answer");
   trig_zero_a: assert property (rd_test |-> PRDATA_O[31:6] == 26'h000_0000)
      else $error("trigger or reserved bit reads nonzero");
   tgt_bit0_a: assert property (rd_tgt |-> PRDATA_O[31:8] == 24'h00_0000 && !PRDATA_O[0])
      else $error("target entry reserved bits read nonzero");
   frame_cause_a: assert property (!FRAME_VALID_I |=> !FRAME_VALID_O)
      else $error("forward frame sent without an input byte");
   remap_strobe_a: assert property (remap_req |=> REMAP_VALID_O && REMAP_ADDR_O[0] == $past(ADDR_RW_I))
      else $error("remapped address missing or direction lost");
   remap_quiet_a: assert property (!remap_req |=> !REMAP_VALID_O)
      else $error("remap strobe without a matching alias");
   abort_cause_a: assert property (!CHK_ERROR_I && !CRC_ERROR_I |=> !ABORT_O)
      else $error("abort without an error");
endmodule
bind ccfi_top ccfi_top_checker u_checker (.SYS_CLK_I, .RESET_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I,
   .PREADY_O, .PRDATA_O, .FRAME_VALID_I, .FRAME_VALID_O, .ADDR_VALID_I, .ALIAS_IDX_I, .ADDR_RW_I,
   .REMAP_VALID_O, .REMAP_ADDR_O, .CHK_ERROR_I, .CRC_ERROR_I, .ABORT_O);
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench of the side channel fault block.
`default_nettype none
`include "ccfi_params.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import ccfi_pkg::*;
   localparam logic [11:0] CFG_A  = {2'b00, `CCFI_IDX_CONFIG, 2'b00};
   localparam logic [11:0] TEST_A = {2'b00, `CCFI_IDX_TEST, 2'b00};
   localparam logic [11:0] TGT_A  = {2'b00, `CCFI_IDX_TGT1, 2'b00};
   logic          clk = 1'b0, rst = 1'b1;                  // Clock and synchronous reset.
   logic          psel = 1'b0, pen = 1'b0, pwr = 1'b0;     // Bus request.
   logic [11:0]   padr = 12'h000;                          // Bus address.
   logic [31:0]   pwd = 32'h0000_0000, prd;                // Bus data.
   logic          prdy, perr, fvo, rvo, abo;               // Design strobes.
   logic          fv = 1'b0, av = 1'b0, arw = 1'b0;        // Byte and address phase strobes.
   logic          chk = 1'b0, crc = 1'b0;                  // Error pulses.
   logic [1:0]    aidx = 2'b00;                            // Alias that matched.
   logic [7:0]    rao, gaps, bad;                          // Remap result and far end counts.
   logic [3:0]    seq = 4'h0;                              // Expected next sequence number.
   ccfi_payload_t fin = '0;                                // Byte offered to the block.
   ccfi_frame_t   fo;                                      // Frame sent on the link.
   int            miscompares = 0, total_checks = 0, cycles = 0;
   ccfi_top dut (.SYS_CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
      .PADDR_I(padr), .PWDATA_I(pwd), .PSTRB_I(4'hF), .PREADY_O(prdy), .PRDATA_O(prd), .PSLVERR_O(perr),
      .FRAME_VALID_I(fv), .FRAME_I(fin), .FRAME_VALID_O(fvo), .FRAME_O(fo), .ADDR_VALID_I(av),
      .ALIAS_IDX_I(aidx), .ADDR_RW_I(arw), .REMAP_VALID_O(rvo), .REMAP_ADDR_O(rao),
      .CHK_ERROR_I(chk), .CRC_ERROR_I(crc), .ABORT_O(abo));
   ccfi_deser_model far (.clk_i(clk), .rst_i(rst), .frame_valid_i(fvo), .frame_i(fo),
      .seq_gaps_o(gaps), .crc_bad_o(bad));
   // Free running clock of 50 ns.
   always #25 clk = ~clk;
   // A hang is cut short well after the planned run.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      if (miscompares == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // One bus transfer; the request stands until the answer is seen at a rising edge, or gives up after 20 more edges without it.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      padr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (prdy !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk);
      end
      `CHK(prdy, 1'b1)
      r = prd;
      e = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] x, input logic xe);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      `CHK(r, {24'h00_0000, x})
      `CHK(e, xe)
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, {24'h00_0000, d}, r, e);
   endtask
   // Address phase through alias idx; zero means no alias matched.
   task automatic remap(input logic [1:0] idx, input logic [7:0] v);
      @(posedge clk);
      av <= 1'b1;
      aidx <= idx;
      arw <= idx[0];
      @(posedge clk);
      av <= 1'b0;
      @(negedge clk);
      `CHK(rvo, idx != 2'b00)
      if (idx != 2'b00) begin
         `CHK(rao, {v[7:1], idx[0]})
      end
   endtask
   task automatic abort_try(input logic c, input logic r, input logic x);
      @(posedge clk);
      chk <= c;
      crc <= r;
      @(posedge clk);
      chk <= 1'b0;
      crc <= 1'b0;
      @(negedge clk);
      `CHK(abo, x)
   endtask
   // Eight byte transfer, one byte every other cycle, with the fault expected at byte s.
   task automatic xfer(input logic [2:0] t, input logic [2:0] s);
      logic [7:0] d, x;
      logic       hit;
      for (int i = 0; i < 8; i++) begin
         d = 8'h30 + 8'(i);
         hit = (3'(i) == s);
         @(posedge clk);
         fv <= 1'b1;
         fin <= '{i == 0, i == 0, d, d ^ 8'h5A};
         @(posedge clk);
         fv <= 1'b0;
         @(negedge clk);
         `CHK(fvo, !(hit && t == 3'b011))
         if (fvo === 1'b1) begin
            x = fo.pay.data ^ d;
            `CHK(fo.seq, seq + 4'(hit && t == 3'b010))
            `CHK(fo.pay.crc, (hit && t == 3'b001) ? ~(d ^ 8'h5A) : (d ^ 8'h5A))
            if (hit && t == 3'b100) begin
               `CHK($countones(x) == 1 && !x[0], 1'b1)
            end else begin
               `CHK(x, (hit && t == 3'b101) ? 8'h01 : 8'h00)
            end
         end
         seq = seq + 4'h1 + 4'(hit && t == 3'b010);
      end
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rd(CFG_A, 8'h20, 1'b0);
      rd(TEST_A, 8'h00, 1'b0);
      for (int n = 0; n < 3; n++) begin
         rd(TGT_A + 12'(4 * n), 8'h00, 1'b0);
      end
      rd(12'h004, 8'h00, 1'b1);
      // Odd values show that bit 0 never sticks.
      for (int n = 0; n < 3; n++) begin
         wr(TGT_A + 12'(4 * n), 8'hA3 + 8'(n * 34));
         rd(TGT_A + 12'(4 * n), (8'hA3 + 8'(n * 34)) & 8'hFE, 1'b0);
      end
      for (int n = 0; n < 4; n++) begin
         remap(2'(n), 8'hA3 + 8'(n * 34 - 34));
      end
      wr(CFG_A, 8'h10);
      abort_try(1'b1, 1'b0, 1'b0);
      abort_try(1'b0, 1'b1, 1'b0);
      wr(CFG_A, 8'h01);
      abort_try(1'b1, 1'b0, 1'b1);
      abort_try(1'b0, 1'b1, 1'b0);
      wr(CFG_A, 8'h11);
      abort_try(1'b0, 1'b1, 1'b1);
      // Only the six defined fault codes are programmed.
      for (int t = 0; t < 6; t++) begin
         wr(TEST_A, {2'b01, 3'(t), 3'(t * 3)});
         rd(TEST_A, {2'b00, 3'(t), 3'(t * 3)}, 1'b0);
         xfer(3'(t), 3'(t * 3));
         xfer(3'b000, 3'b000);
      end
      `CHK(gaps, 8'h02)
      `CHK(bad, 8'h03)
      tally_and_finish();
   end
endmodule
`default_nettype wire
